// >>> src/ims_ctrl.v
// interrupt and macro service unit with axi4-lite registers
// ========================================
// How it works
// R1: 25 requests; software picks vectored or macro service per source.
// R2: vectored accept reads handler address from vector entry, jumps there.
// R3: each vectored source is set to one of two priority levels.
// R4: nmi uses 0002H, maskables 0004H to 0032H stepping two bytes.
// R5: simultaneous maskables resolved by fixed order, 0 highest, 23 lowest.
// R6: every maskable source can use macro service instead.
// R7: macro service runs without cpu, no sp or psw save.
// R8: transfer mode moves one byte between sfr and FE00H..FEFFH.
// R9: buffer low address equals channel pointer minus service counter.
// R10: transfer mode raises vectored interrupt when count is done.
// R11: port mode loads next pattern to port0 buffers and compare.
// R12: without ring reload, port mode raises vectored interrupt when the count reaches zero.
// R13: ring counter reloads from modulo register on reaching zero.
// R14: counter mode decrements counter; vectored interrupt at zero.
// R15: pattern mode shifts control flop bit right into buffer.
// R16: pattern mode interrupts when buffer equals comparison area.
// R17: optional interrupt after set number of samples regardless of match.
// R18: each macro mode only for its permitted sources.
// R19: counter mode selectable for every maskable source.
// R20: pending flag clears when request accepted, vectored or macro.
`include "ims_map.vh"
`timescale 1ns/10ps
`default_nettype none
module ims_ctrl (
  input wire mclk,
  input wire reset,
  input wire [23:0] irq_in,
  input wire nmi_pin,
  input wire control_track_flop,
  input wire cpu_int_ack,
  input wire cpu_int_busy,
  output reg cpu_int_req,
  output reg [15:0] cpu_vec_addr,
  output reg cpu_int_high,
  output reg mem_req,
  output reg mem_we,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire mem_ack,
  output reg [4:0] sfr_src,
  output reg sfr_we,
  output reg [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  output reg port0_load,
  output reg [7:0] port0_low_buffer,
  output reg [7:0] port0_high_buffer,
  output reg cmp_load_one,
  output reg cmp_load_two,
  output reg [15:0] cmp_value,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // ========================================
  // states
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_VEC = 6'b000010;
  localparam [5:0] ST_RD = 6'b000100;
  localparam [5:0] ST_WR = 6'b001000;
  localparam [5:0] ST_PORT = 6'b010000;
  localparam [5:0] ST_DONE = 6'b100000;
  localparam [4:0] NMI_ID = 5'h1F;
  // ========================================
  // synchronisers for pins and peripheral edges
  reg [23:0] irq_s1_q, irq_s2_q, irq_s3_q;
  reg nmi_s1_q, nmi_s2_q, nmi_s3_q, ctl_s1_q, ctl_s2_q;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_s1_q <= 24'h000000;
      irq_s2_q <= 24'h000000;
      irq_s3_q <= 24'h000000;
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_s3_q <= 1'b0;
      ctl_s1_q <= 1'b0;
      ctl_s2_q <= 1'b0;
    end else begin
      irq_s1_q <= irq_in;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
      nmi_s1_q <= nmi_pin;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
      ctl_s1_q <= control_track_flop;
      ctl_s2_q <= ctl_s1_q;
    end
  end
  wire [23:0] irq_rise = irq_s2_q & ~irq_s3_q;
  wire nmi_rise = nmi_s2_q & ~nmi_s3_q;
  // ========================================
  // software state
  reg [23:0] pend_q, mask_q, prio_q, msen_q;
  reg nmi_pend_q, gie_q;
  reg [4:0] chsel_q;
  reg [7:0] cfg_q [0:23];
  reg [7:0] ptr_q [0:23];
  reg [7:0] cnt_q [0:23];
  reg [15:0] aux_q [0:23];
  reg [7:0] cmpa_q [0:23];
  reg [7:0] buf_q [0:23];
  reg [5:0] st_q;
  reg [4:0] cur_q;
  reg [7:0] data_q;
  reg [7:0] last_vec_q;
  // ========================================
  // arbitration
  // R5: fixed order
  reg [4:0] win_hi, win_lo;
  reg any_hi, any_lo;
  integer i;
  integer j;
  wire [23:0] ready_req = pend_q & ~mask_q;
  always @* begin
    win_hi = 5'd0;
    win_lo = 5'd0;
    any_hi = 1'b0;
    any_lo = 1'b0;
    for (i = `IMS_NSRC - 1; i >= 0; i = i - 1) begin
      // R3: two levels
      if (ready_req[i] && prio_q[i]) begin
        win_hi = i[4:0];
        any_hi = 1'b1;
      end
      if (ready_req[i] && !prio_q[i]) begin
        win_lo = i[4:0];
        any_lo = 1'b1;
      end
    end
  end
  wire [4:0] win = any_hi ? win_hi : win_lo;
  wire any_req = any_hi | any_lo;
  // R18: permitted modes
  function mode_ok;
    input [4:0] s;
    input [1:0] m;
    begin
      case (m)
        `IMS_MODE_XFER: mode_ok = (s == `IMS_SRC_SER0) || (s == `IMS_SRC_SER1) || (s == `IMS_SRC_ADC) ||
          (s == `IMS_SRC_T3) || (s == `IMS_SRC_T4) || (s == `IMS_SRC_T5) || (s == `IMS_SRC_UDC);
        `IMS_MODE_PORT: mode_ok = (s == `IMS_SRC_T0M1) || (s == `IMS_SRC_T0M2);
        `IMS_MODE_PAT: mode_ok = (s == `IMS_SRC_CAP12) || (s == `IMS_SRC_T3);
        // R19: counter always
        default: mode_ok = 1'b1;
      endcase
    end
  endfunction
  wire [7:0] ccfg = cfg_q[cur_q];
  wire [7:0] ccnt = cnt_q[cur_q];
  wire [7:0] cptr = ptr_q[cur_q];
  wire [15:0] caux = aux_q[cur_q];
  wire [1:0] cmode = ccfg[1:0];
  // R9: pointer minus counter
  wire [7:0] xfer_lo = cptr - ccnt;
  wire [7:0] cnt_dec = ccnt - 8'h01;
  wire [7:0] shifted = {ctl_s2_q, buf_q[cur_q][7:1]};
  // R4: vector entries two bytes apart
  wire [15:0] vec_of = `IMS_VEC_BASE + {10'h000, cur_q, 1'b0};
  wire macro_go = msen_q[win] && mode_ok(win, cfg_q[win][1:0]);
  // ========================================
  // axi4-lite slave
  reg [7:0] aw_q;
  reg aw_have_q, w_have_q;
  reg [31:0] w_q;
  wire do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
  wire [7:0] sel = {3'b000, chsel_q};
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IMS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `IMS_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      aw_q <= 8'h00;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      w_q <= 32'h00000000;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= s_axi_wdata;
        w_have_q <= 1'b1;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_q > `IMS_REG_CHBUF || aw_q[1:0] != 2'b00) ? `IMS_RESP_SLVERR : `IMS_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `IMS_RESP_OKAY;
        case (s_axi_araddr)
          `IMS_REG_PEND: s_axi_rdata <= {8'h00, pend_q};
          `IMS_REG_MASK: s_axi_rdata <= {8'h00, mask_q};
          `IMS_REG_PRIO: s_axi_rdata <= {8'h00, prio_q};
          `IMS_REG_MSEN: s_axi_rdata <= {8'h00, msen_q};
          `IMS_REG_CTRL: s_axi_rdata <= {31'h00000000, gie_q};
          `IMS_REG_STAT: s_axi_rdata <= {16'h0000, last_vec_q, 1'b0, nmi_pend_q, st_q};
          `IMS_REG_CHSEL: s_axi_rdata <= {27'h0000000, chsel_q};
          `IMS_REG_CHCFG: s_axi_rdata <= {24'h000000, cfg_q[chsel_q]};
          `IMS_REG_CHPTR: s_axi_rdata <= {24'h000000, ptr_q[chsel_q]};
          `IMS_REG_CHCNT: s_axi_rdata <= {24'h000000, cnt_q[chsel_q]};
          `IMS_REG_CHAUX: s_axi_rdata <= {16'h0000, aux_q[chsel_q]};
          `IMS_REG_CHCMP: s_axi_rdata <= {24'h000000, cmpa_q[chsel_q]};
          `IMS_REG_CHBUF: s_axi_rdata <= {24'h000000, buf_q[chsel_q]};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `IMS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ========================================
  // service engine and register writes
  wire accept = (st_q == ST_IDLE) && !cpu_int_busy && (nmi_pend_q || (gie_q && any_req));
  wire [23:0] take_mask = (accept && !nmi_pend_q) ? (24'h000001 << win) : 24'h000000;
  wire [23:0] wr_pend_clr = (do_wr && aw_q == `IMS_REG_PEND) ? w_q[23:0] : 24'h000000;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pend_q <= 24'h000000;
      mask_q <= 24'hFFFFFF;
      prio_q <= 24'h000000;
      msen_q <= 24'h000000;
      nmi_pend_q <= 1'b0;
      gie_q <= 1'b0;
      chsel_q <= 5'd0;
      st_q <= ST_IDLE;
      cur_q <= 5'd0;
      data_q <= 8'h00;
      last_vec_q <= 8'h00;
      cpu_int_req <= 1'b0;
      cpu_vec_addr <= 16'h0000;
      cpu_int_high <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      sfr_src <= 5'd0;
      sfr_we <= 1'b0;
      sfr_wdata <= 8'h00;
      port0_load <= 1'b0;
      port0_low_buffer <= 8'h00;
      port0_high_buffer <= 8'h00;
      cmp_load_one <= 1'b0;
      cmp_load_two <= 1'b0;
      cmp_value <= 16'h0000;
      for (j = 0; j < `IMS_NSRC; j = j + 1) begin
        cfg_q[j] <= 8'h00;
        ptr_q[j] <= 8'h00;
        cnt_q[j] <= 8'h00;
        aux_q[j] <= 16'h0000;
        cmpa_q[j] <= 8'h00;
        buf_q[j] <= 8'h00;
      end
    end else begin
      sfr_we <= 1'b0;
      port0_load <= 1'b0;
      cmp_load_one <= 1'b0;
      cmp_load_two <= 1'b0;
      // R20: set wins over clear, accept clears
      pend_q <= (pend_q & ~take_mask & ~wr_pend_clr) | irq_rise;
      nmi_pend_q <= (nmi_pend_q & ~(accept && nmi_pend_q)) | nmi_rise;
      if (do_wr) begin
        case (aw_q)
          `IMS_REG_MASK: mask_q <= w_q[23:0];
          // R3: level select
          `IMS_REG_PRIO: prio_q <= w_q[23:0];
          // R1: mode per source
          `IMS_REG_MSEN: msen_q <= w_q[23:0];
          `IMS_REG_CTRL: gie_q <= w_q[0];
          `IMS_REG_CHSEL: chsel_q <= (w_q[4:0] < `IMS_NSRC) ? w_q[4:0] : 5'd0;
          `IMS_REG_CHCFG: cfg_q[sel[4:0]] <= w_q[7:0];
          `IMS_REG_CHPTR: ptr_q[sel[4:0]] <= w_q[7:0];
          `IMS_REG_CHCNT: cnt_q[sel[4:0]] <= w_q[7:0];
          `IMS_REG_CHAUX: aux_q[sel[4:0]] <= w_q[15:0];
          `IMS_REG_CHCMP: cmpa_q[sel[4:0]] <= w_q[7:0];
          `IMS_REG_CHBUF: buf_q[sel[4:0]] <= w_q[7:0];
          default: gie_q <= gie_q;
        endcase
      end
      case (st_q)
        ST_IDLE: begin
          if (accept) begin
            if (nmi_pend_q) begin
              // R4: nmi entry
              cur_q <= NMI_ID;
              cpu_vec_addr <= `IMS_VEC_NMI;
              cpu_int_high <= 1'b1;
              cpu_int_req <= 1'b1;
              st_q <= ST_VEC;
            end else begin
              cur_q <= win;
              // R6: macro instead of vector
              if (macro_go) begin
                st_q <= ST_RD;
              end else begin
                // R2: vector to cpu
                cpu_vec_addr <= `IMS_VEC_BASE + {10'h000, win, 1'b0};
                cpu_int_high <= prio_q[win];
                cpu_int_req <= 1'b1;
                st_q <= ST_VEC;
              end
            end
          end
        end
        ST_VEC: begin
          if (cpu_int_ack) begin
            cpu_int_req <= 1'b0;
            last_vec_q <= cpu_vec_addr[7:0];
            st_q <= ST_IDLE;
          end
        end
        // R7: macro steps need no cpu state
        ST_RD: begin
          case (cmode)
            `IMS_MODE_XFER: begin
              // R8: byte in page FE
              mem_addr <= {`IMS_PAGE_HI, xfer_lo};
              sfr_src <= cur_q;
              mem_we <= ccfg[`IMS_CFG_DIR];
              mem_wdata <= sfr_rdata;
              mem_req <= 1'b1;
              st_q <= ST_WR;
            end
            `IMS_MODE_PORT: begin
              mem_addr <= {`IMS_PAGE_HI, xfer_lo};
              mem_we <= 1'b0;
              mem_req <= 1'b1;
              st_q <= ST_PORT;
            end
            `IMS_MODE_PAT: begin
              // R15: right shift
              buf_q[cur_q] <= shifted;
              cnt_q[cur_q] <= cnt_dec;
              // R16: match, R17: sample count option
              if (shifted == cmpa_q[cur_q] || (ccfg[`IMS_CFG_NCNT] && cnt_dec == 8'h00)) begin
                cpu_vec_addr <= vec_of;
                cpu_int_high <= prio_q[cur_q];
                cpu_int_req <= 1'b1;
                st_q <= ST_VEC;
              end else begin
                st_q <= ST_IDLE;
              end
            end
            default: begin
              // R14: count down, vector at zero
              cnt_q[cur_q] <= cnt_dec;
              st_q <= ST_DONE;
            end
          endcase
        end
        ST_WR: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            if (!ccfg[`IMS_CFG_DIR]) begin
              sfr_we <= 1'b1;
              sfr_wdata <= mem_rdata;
            end
            cnt_q[cur_q] <= cnt_dec;
            st_q <= ST_DONE;
          end
        end
        ST_PORT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            // R11: pattern and timing load
            port0_load <= 1'b1;
            if (cur_q == `IMS_SRC_T0M1) begin
              port0_low_buffer <= mem_rdata;
              cmp_load_one <= 1'b1;
            end else begin
              port0_high_buffer <= mem_rdata;
              cmp_load_two <= 1'b1;
            end
            cmp_value <= {caux[15:8], mem_rdata};
            cnt_q[cur_q] <= cnt_dec;
            // R13: ring reload from modulo
            if (ccfg[`IMS_CFG_RING] && cnt_dec == 8'h00) begin
              cnt_q[cur_q] <= caux[7:0];
              st_q <= ST_IDLE;
            end else begin
              st_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          // R10: R12: R14: end of count
          if (ccnt == 8'h00) begin
            cpu_vec_addr <= vec_of;
            cpu_int_high <= prio_q[cur_q];
            cpu_int_req <= 1'b1;
            st_q <= ST_VEC;
          end else begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // ims_ctrl
`default_nettype wire

// >>> src/ims_map.vh
// register map, field positions and constants of the interrupt and macro service unit
`ifndef IMS_MAP_VH
`define IMS_MAP_VH
// axi4-lite byte offsets
`define IMS_REG_PEND 8'h00
`define IMS_REG_MASK 8'h04
`define IMS_REG_PRIO 8'h08
`define IMS_REG_MSEN 8'h0C
`define IMS_REG_CTRL 8'h10
`define IMS_REG_STAT 8'h14
`define IMS_REG_CHSEL 8'h18
`define IMS_REG_CHCFG 8'h1C
`define IMS_REG_CHPTR 8'h20
`define IMS_REG_CHCNT 8'h24
`define IMS_REG_CHAUX 8'h28
`define IMS_REG_CHCMP 8'h2C
`define IMS_REG_CHBUF 8'h30
// sources
`define IMS_NSRC 24
`define IMS_NSRC_W 5
// vector entries
`define IMS_VEC_NMI 16'h0002
`define IMS_VEC_BASE 16'h0004
// macro data page
`define IMS_PAGE_HI 8'hFE
// macro modes (chcfg bits 1:0)
`define IMS_MODE_XFER 2'h0
`define IMS_MODE_PORT 2'h1
`define IMS_MODE_CNT 2'h2
`define IMS_MODE_PAT 2'h3
// chcfg fields
`define IMS_CFG_DIR 2
`define IMS_CFG_RING 3
`define IMS_CFG_NCNT 4
// source numbers by default priority
`define IMS_SRC_CAP12 5'd3
`define IMS_SRC_T0M1 5'd7
`define IMS_SRC_T0M2 5'd8
`define IMS_SRC_SER0 5'd12
`define IMS_SRC_ADC 5'd14
`define IMS_SRC_UDC 5'd16
`define IMS_SRC_T3 5'd17
`define IMS_SRC_T4 5'd18
`define IMS_SRC_T5 5'd19
`define IMS_SRC_SER1 5'd21
// axi responses
`define IMS_RESP_OKAY 2'h0
`define IMS_RESP_SLVERR 2'h2
`endif

// >>> testbench/ims_ctrl_checker.sv
// concurrent checks on the ports of the interrupt and macro service unit
`timescale 1ns/10ps
`default_nettype none
module ims_ctrl_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic nmi_pin,
  input wire logic cpu_int_busy,
  input wire logic cpu_int_ack,
  input wire logic cpu_int_req,
  input wire logic [15:0] cpu_vec_addr,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic sfr_we,
  input wire logic [4:0] sfr_src,
  input wire logic cmp_load_one,
  input wire logic cmp_load_two
);
  // ========================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_vec_tab;
    cpu_int_req |-> cpu_vec_addr == 16'h0002 || (cpu_vec_addr inside {[16'h0004:16'h0032]} && !cpu_vec_addr[0]);
  endproperty
  a_vec_tab: assert property (p_vec_tab) else $error("vector outside table");
  property p_vec_hold;
    cpu_int_req && !cpu_int_ack |=> cpu_int_req && $stable(cpu_vec_addr);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector dropped before ack");
  property p_ack_drop;
    cpu_int_req && cpu_int_ack |=> !cpu_int_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request stays after ack");
  // nmi ignores enables, so an idle unit must offer entry 0002 soon
  property p_nmi_vec;
    $rose(nmi_pin) && !cpu_int_req && !mem_req && !cpu_int_busy |-> ##[1:12] cpu_int_req && cpu_vec_addr == 16'h0002;
  endproperty
  a_nmi_vec: assert property (p_nmi_vec) else $error("nonmaskable not vectored");
  property p_page;
    mem_req |-> mem_addr[15:8] == 8'hFE;
  endproperty
  a_page: assert property (p_page) else $error("memory access off page");
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request changed");
  property p_sfr_src;
    sfr_we |-> sfr_src inside {5'd12, 5'd14, 5'd16, 5'd17, 5'd18, 5'd19, 5'd21};
  endproperty
  a_sfr_src: assert property (p_sfr_src) else $error("transfer from bad source");
  property p_cmp_one;
    !(cmp_load_one && cmp_load_two);
  endproperty
  a_cmp_one: assert property (p_cmp_one) else $error("both compares loaded");
endmodule // ims_ctrl_checker
bind ims_ctrl ims_ctrl_checker u_chk (.*);
`default_nettype wire

// >>> testbench/ims_far_model.sv
// cpu core and data memory model on the far side of the unit
`timescale 1ns/10ps
`default_nettype none
module ims_far_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cpu_int_req,
  output logic cpu_int_ack,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  // ========================================
  // cpu takes a vector late, memory alternates prompt and slow answers
  logic [7:0] ram [0:255];
  logic [1:0] ack_wait_q;
  logic [1:0] mem_wait_q;
  logic [1:0] mem_lim_q;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpu_int_ack <= 1'b0;
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      ack_wait_q <= 2'h0;
      mem_wait_q <= 2'h0;
      mem_lim_q <= 2'h0;
    end else begin
      cpu_int_ack <= 1'b0;
      mem_ack <= 1'b0;
      // released data toggles so a stale byte never looks valid
      mem_rdata <= ~mem_rdata;
      ack_wait_q <= (cpu_int_req && !cpu_int_ack) ? ack_wait_q + 2'h1 : 2'h0;
      if (cpu_int_req && !cpu_int_ack && ack_wait_q == 2'h2)
        cpu_int_ack <= 1'b1;
      mem_wait_q <= (mem_req && !mem_ack) ? mem_wait_q + 2'h1 : 2'h0;
      if (mem_req && !mem_ack && mem_wait_q == mem_lim_q) begin
        mem_ack <= 1'b1;
        mem_lim_q <= mem_lim_q ^ 2'h3;
        mem_rdata <= ram[mem_addr[7:0]];
        if (mem_we)
          ram[mem_addr[7:0]] <= mem_wdata;
      end
    end
  end
endmodule // ims_far_model
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the interrupt and macro service unit
`timescale 1ns/10ps
`default_nettype none
`include "ims_map.vh"
module tb;
  logic mclk, reset, nmi_pin, control_track_flop, cpu_int_ack, cpu_int_busy, cpu_int_req, cpu_int_high;
  logic mem_req, mem_we, mem_ack, sfr_we, port0_load, cmp_load_one, cmp_load_two;
  logic [23:0] irq_in;
  logic [15:0] cpu_vec_addr, mem_addr, cmp_value;
  logic [7:0] mem_wdata, mem_rdata, sfr_rdata, sfr_wdata, port0_low_buffer, port0_high_buffer;
  logic [4:0] sfr_src;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  integer fail_count, checks, seed, i, a, b;
  logic [16:0] vq[$], ev[$];
  logic [23:0] mq[$], em[$];
  logic [7:0] v, pat, buf_m;
  ims_ctrl dut (.*);
  ims_far_model far (.*);
  always #4 mclk = ~mclk;
  // ========================================
  // observed vectors and memory writes
  always @(posedge mclk) begin
    if (cpu_int_req && cpu_int_ack) vq.push_back({cpu_int_high, cpu_vec_addr});
    if (mem_req && mem_ack && mem_we) mq.push_back({mem_addr, mem_wdata});
  end
  // ========================================
  // helpers
  task automatic results;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (e !== s) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [16:0] vec(input integer s, input logic h);
    vec = {h, `IMS_VEC_BASE + 16'(2 * s)};
  endfunction
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    integer n;
    n = 0;
    if (w) begin
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    end else begin
      s_axi_araddr <= ad;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
    end
    while (n >= 0) begin
      @(posedge mclk);
      n++;
      if (n > 100) begin
        fail_count++;
        results;
      end
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w && s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        n = -1;
      end
      if (!w && s_axi_rvalid) begin
        r = s_axi_rresp;
        q = s_axi_rdata;
        s_axi_rready <= 1'b0;
        n = -1;
      end
    end
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d);
    chk("write response", `IMS_RESP_OKAY, r);
  endtask
  task automatic rd(input string n, input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk(n, e, q);
  endtask
  task automatic pulse(input logic [23:0] m);
    irq_in <= irq_in | m;
    repeat (4) @(posedge mclk);
    irq_in <= irq_in & ~m;
    repeat (4) @(posedge mclk);
  endtask
  // waits for the modelled traffic, then a quiet spell to catch extras
  task automatic expect_all(input string n);
    integer k;
    for (k = 0; k < 300 && (vq.size() < ev.size() || mq.size() < em.size()); k++) @(posedge mclk);
    if (k == 300) begin
      fail_count++;
      results;
    end
    repeat (20) @(posedge mclk);
    chk({n, " count"}, ev.size() + em.size(), vq.size() + mq.size());
    while (ev.size() && vq.size()) chk({n, " vector"}, ev.pop_front(), vq.pop_front());
    while (em.size() && mq.size()) chk({n, " memory"}, em.pop_front(), mq.pop_front());
    ev.delete();
    vq.delete();
    em.delete();
    mq.delete();
    $display("test %s done", n);
  endtask
  // ========================================
  // main sequence
  initial begin
    seed = 32'h836E3E64;
    fail_count = 0;
    checks = 0;
    mclk = 1'b0;
    reset = 1'b1;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {irq_in, nmi_pin, control_track_flop, cpu_int_busy, sfr_rdata, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd("mask reset", `IMS_REG_MASK, 32'h00FFFFFF);
    rd("pending reset", `IMS_REG_PEND, 32'h0);
    rd("unmapped", 8'h3C, 32'h0);
    chk("unmapped response", `IMS_RESP_SLVERR, r);
    wr(`IMS_REG_MASK, 32'h0);
    wr(`IMS_REG_CTRL, 32'h1);
    for (i = 0; i < 4; i++) begin
      a = {$random(seed)} % 24;
      b = (a + 1 + {$random(seed)} % 23) % 24;
      v = $random(seed);
      wr(`IMS_REG_PRIO, ({31'h0, v[0]} << a) | ({31'h0, v[1]} << b));
      // high level first, default order breaks a tie
      if (v[0] != v[1] ? v[0] : a < b) begin
        ev.push_back(vec(a, v[0]));
        ev.push_back(vec(b, v[1]));
      end else begin
        ev.push_back(vec(b, v[1]));
        ev.push_back(vec(a, v[0]));
      end
      pulse((24'h1 << a) | (24'h1 << b));
      expect_all("vectored order");
      rd("pending cleared", `IMS_REG_PEND, 32'h0);
    end
    wr(`IMS_REG_CTRL, 32'h0);
    nmi_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    nmi_pin <= 1'b0;
    ev.push_back({1'b1, `IMS_VEC_NMI});
    expect_all("nonmaskable");
    wr(`IMS_REG_CTRL, 32'h1);
    wr(`IMS_REG_PRIO, 32'h0);
    a = {$random(seed)} % 24;
    wr(`IMS_REG_MSEN, 32'h1 << a);
    wr(`IMS_REG_CHSEL, a);
    wr(`IMS_REG_CHCFG, {30'h0, `IMS_MODE_CNT});
    wr(`IMS_REG_CHCNT, 32'h3);
    pulse(24'h1 << a);
    pulse(24'h1 << a);
    expect_all("counter early");
    rd("counter value", `IMS_REG_CHCNT, 32'h1);
    pulse(24'h1 << a);
    ev.push_back(vec(a, 1'b0));
    expect_all("counter end");
    wr(`IMS_REG_MSEN, 32'h1 << 14);
    wr(`IMS_REG_CHSEL, 32'd14);
    wr(`IMS_REG_CHCFG, 32'h4);
    wr(`IMS_REG_CHPTR, 32'h10);
    wr(`IMS_REG_CHCNT, 32'h2);
    for (i = 2; i > 0; i--) begin
      v = $random(seed);
      sfr_rdata <= v;
      em.push_back({8'hFE, 8'h10 - 8'(i), v});
      pulse(24'h1 << 14);
    end
    ev.push_back(vec(14, 1'b0));
    expect_all("data transfer");
    wr(`IMS_REG_MSEN, 32'h1);
    wr(`IMS_REG_CHSEL, 32'h0);
    wr(`IMS_REG_CHCFG, 32'h0);
    pulse(24'h1);
    ev.push_back(vec(0, 1'b0));
    expect_all("mode not permitted");
    wr(`IMS_REG_MSEN, 32'h8);
    wr(`IMS_REG_CHSEL, 32'h3);
    wr(`IMS_REG_CHCFG, 32'h3);
    wr(`IMS_REG_CHCNT, 32'hFF);
    wr(`IMS_REG_CHBUF, 32'h0);
    pat = $random(seed);
    wr(`IMS_REG_CHCMP, {24'h0, pat});
    buf_m = 8'h00;
    for (i = 0; i < 8; i++) begin
      control_track_flop <= pat[i];
      buf_m = {pat[i], buf_m[7:1]};
      if (buf_m == pat) ev.push_back(vec(3, 1'b0));
      pulse(24'h8);
    end
    expect_all("pattern match");
    rd("pattern buffer", `IMS_REG_CHBUF, {24'h0, buf_m});
    wr(`IMS_REG_CHCFG, 32'h13);
    wr(`IMS_REG_CHCNT, 32'h2);
    wr(`IMS_REG_CHCMP, 32'hFF);
    control_track_flop <= 1'b0;
    pulse(24'h8);
    pulse(24'h8);
    ev.push_back(vec(3, 1'b0));
    expect_all("sample count");
    // the last transferred byte sits at page offset 0F and serves as the profile
    wr(`IMS_REG_MSEN, 32'h80);
    wr(`IMS_REG_CHSEL, 32'h7);
    wr(`IMS_REG_CHCFG, 32'h1);
    wr(`IMS_REG_CHPTR, 32'h10);
    wr(`IMS_REG_CHCNT, 32'h1);
    wr(`IMS_REG_CHAUX, 32'hAB00);
    pulse(24'h80);
    ev.push_back(vec(7, 1'b0));
    expect_all("port profile");
    chk("port pattern", {24'h0, v}, {24'h0, port0_low_buffer});
    chk("port timing", {16'h0, 8'hAB, v}, {16'h0, cmp_value});
    results;
  end
endmodule // tb
`default_nettype wire
